/* hw/liu_system_side_pins.v */
// System-side pin logic of the line interface: data pins, clocks, loss output, bus flavour.
// Assumes pins and link clocks are asynchronous to pclk and are sampled here.
`default_nettype none
`include "liu_pins_map.vh"

// Contract
// - Parallel port uses strobe timing when flavour pin is 1, else read/write strobes.
// - Strobe flavour turns read, latch, write pins into data strobe, address strobe, direction.
// - Receive clock is recovered clock, or master-clock derived when line is silent.
// - Loss source select zero: loss output high during receive carrier loss.
// - Loss source select one: loss output high after five microseconds without transmit clock.
// - Pin-configured mode defaults loss source select to zero.
// - Receive data updates on rising clock edge if select is 0, falling if 1.
// - NRZ mode: data on positive pin, error pulses on negative pin.
// - Transmit data sampled on falling clock edge if select is 0, rising if 1.
// - Transmit clock comes from pin, master clock or recovered clock.
// - Tri-state input high releases only the receive clock, receive data and loss outputs.
// - Hardware reset clears every control bit to zero.
// - Parallel port is active only while upper interface select is 0.
// - Master reference clock drives recovery logic.
module liu_system_side_pins (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire hw_reset_n,
  input wire hw_mode,
  input wire tristate_ctrl,
  input wire bus_flavor_select,
  input wire bus_iface_select_hi,
  input wire read_or_data_strobe_n,
  input wire address_latch_strobe,
  input wire write_or_direction,
  output reg host_read_strobe,
  output reg host_write_strobe,
  output reg host_addr_strobe,
  output reg strobe_flavor,
  output reg parallel_active,
  input wire master_clock,
  input wire recovered_clock,
  input wire line_signal_present,
  input wire rx_pos_in,
  input wire rx_neg_in,
  input wire rx_error_in,
  output reg rx_line_clock,
  output reg rx_line_clock_oe,
  output reg rx_positive_data,
  output reg rx_negative_data,
  output reg rx_data_oe,
  input wire tx_line_clock,
  input wire tx_positive_data,
  input wire tx_negative_data,
  output reg tx_pos_sampled,
  output reg tx_neg_sampled,
  output reg tx_sample_valid,
  output reg loss_indicator_out,
  output reg loss_indicator_oe
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam NSYNC = 14;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] sync_a;
  reg [NSYNC-1:0] sync_b;
  reg [NSYNC-1:0] prev_b;
  assign raw_in = {hw_reset_n, tristate_ctrl, bus_flavor_select, bus_iface_select_hi,
    read_or_data_strobe_n, address_latch_strobe, write_or_direction, master_clock,
    recovered_clock, line_signal_present, tx_line_clock, tx_positive_data,
    tx_negative_data, rx_error_in};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= {NSYNC{1'b0}};
      sync_b <= {NSYNC{1'b0}};
      prev_b <= {NSYNC{1'b0}};
    end else if (clk_en) begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      prev_b <= sync_b;
    end
  end
  wire s_hw_reset_n_n = sync_b[13];
  wire s_tri = sync_b[12];
  wire s_flavor = sync_b[11];
  wire s_bus_iface_select_hi = sync_b[10];
  wire s_rd = sync_b[9];
  wire s_ale = sync_b[8];
  wire s_wr = sync_b[7];
  wire s_mclk = sync_b[6];
  wire s_rclk = sync_b[5];
  wire s_sig = sync_b[4];
  wire s_tx_line_clock = sync_b[3];
  wire s_tx_positive_data = sync_b[2];
  wire s_tx_negative_data = sync_b[1];
  wire s_err = sync_b[0];
  function rise_of;
    input cur;
    input prev;
    begin
      rise_of = cur & ~prev;
    end
  endfunction

  function fall_of;
    input cur;
    input prev;
    begin
      fall_of = ~cur & prev;
    end
  endfunction

  wire mclk_rise = rise_of(s_mclk, prev_b[6]);
  wire mclk_fall = fall_of(s_mclk, prev_b[6]);
  wire rclk_rise = rise_of(s_rclk, prev_b[5]);
  wire rclk_fall = fall_of(s_rclk, prev_b[5]);
  wire pin_tx_line_clock_rise = rise_of(s_tx_line_clock, prev_b[3]);
  wire pin_tx_line_clock_fall = fall_of(s_tx_line_clock, prev_b[3]);

  // ----------------------------------------
  // Mode pin and receive data synchronisers
  // ----------------------------------------
  reg [2:0] pin_a;
  reg [2:0] pin_b;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a <= 3'h0;
      pin_b <= 3'h0;
    end else if (clk_en) begin
      pin_a <= {hw_mode, rx_pos_in, rx_neg_in};
      pin_b <= pin_a;
    end
  end
  wire s_hw_mode = pin_b[2];
  wire s_rx_positive_data = pin_b[1];
  wire s_rx_negative_data = pin_b[0];

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg [`CTRL_WIDTH-1:0] ctrl;
  reg [`EV_WIDTH-1:0] int_stat;
  reg [`EV_WIDTH-1:0] int_mask;
  reg [`EV_WIDTH-1:0] events;
  wire wr_cyc = psel & penable & pwrite & ~pready;
  wire rd_cyc = psel & penable & ~pwrite & ~pready;
  wire hw_clear = ~s_hw_reset_n_n | s_hw_mode;

  function known_addr;
    input [11:0] a;
    begin
      known_addr = (a == `REG_CTRL) | (a == `REG_STATUS) | (a == `REG_INT_STAT) |
        (a == `REG_INT_MASK);
    end
  endfunction

  function [31:0] read_word;
    input [11:0] a;
    input [`CTRL_WIDTH-1:0] c;
    input [`EV_WIDTH-1:0] st;
    input [`EV_WIDTH-1:0] is;
    input [`EV_WIDTH-1:0] im;
    begin
      case (a)
        `REG_CTRL: read_word = {{(32-`CTRL_WIDTH){1'b0}}, c};
        `REG_STATUS: read_word = {{(32-`EV_WIDTH){1'b0}}, st};
        `REG_INT_STAT: read_word = {{(32-`EV_WIDTH){1'b0}}, is};
        `REG_INT_MASK: read_word = {{(32-`EV_WIDTH){1'b0}}, im};
        default: read_word = 32'h00000000;
      endcase
    end
  endfunction

  reg rx_error_in_q;
  reg stall_flag;
  wire [`EV_WIDTH-1:0] cur_status = {rx_error_in_q, stall_flag, ~s_sig};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      int_stat <= {`EV_WIDTH{1'b0}};
      int_mask <= {`EV_WIDTH{1'b0}};
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      pready <= (wr_cyc | rd_cyc);
      pslverr <= (wr_cyc | rd_cyc) & ~known_addr(paddr);
      if (hw_clear) begin
        ctrl <= `CTRL_RESET;
      end else if (wr_cyc && paddr == `REG_CTRL) begin
        ctrl <= pwdata[`CTRL_WIDTH-1:0];
      end
      if (wr_cyc && paddr == `REG_INT_MASK) begin
        int_mask <= pwdata[`EV_WIDTH-1:0];
      end
      if (wr_cyc && paddr == `REG_INT_STAT) begin
        int_stat <= (int_stat & ~pwdata[`EV_WIDTH-1:0]) | events;
      end else begin
        int_stat <= int_stat | events;
      end
      irq <= |(int_stat & int_mask);
      if (rd_cyc) begin
        prdata <= read_word(paddr, ctrl, cur_status, int_stat, int_mask);
      end
    end
  end

  wire rx_edge_sel = ctrl[`CTRL_RX_EDGE];
  wire tx_edge_sel = ctrl[`CTRL_TX_EDGE];
  wire nrz_mode_bit = ctrl[`CTRL_NRZ];
  wire loss_source_select = ctrl[`CTRL_LOSS_SRC];
  wire [1:0] tx_src = ctrl[`CTRL_TX_SRC_HI:`CTRL_TX_SRC_LO];

  // ----------------------------------------
  // Host bus flavour decode
  // ----------------------------------------
  wire par_on = ~s_bus_iface_select_hi;
  wire motor = s_flavor & par_on;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_read_strobe <= 1'b0;
      host_write_strobe <= 1'b0;
      host_addr_strobe <= 1'b0;
      strobe_flavor <= 1'b0;
      parallel_active <= 1'b0;
    end else if (clk_en) begin
      parallel_active <= par_on;
      strobe_flavor <= motor;
      host_addr_strobe <= par_on & s_ale;
      if (motor) begin
        host_read_strobe <= ~s_rd & s_wr;
        host_write_strobe <= ~s_rd & ~s_wr;
      end else begin
        host_read_strobe <= par_on & ~s_rd;
        host_write_strobe <= par_on & ~s_wr;
      end
    end
  end

  // ----------------------------------------
  // Receive clock and data
  // ----------------------------------------
  wire rx_ck = s_sig ? s_rclk : s_mclk;
  wire rx_rise = s_sig ? rclk_rise : mclk_rise;
  wire rx_fall = s_sig ? rclk_fall : mclk_fall;
  wire rx_upd = rx_edge_sel ? rx_fall : rx_rise;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_line_clock <= 1'b0;
      rx_positive_data <= 1'b0;
      rx_negative_data <= 1'b0;
      rx_error_in_q <= 1'b0;
      rx_line_clock_oe <= 1'b0;
      rx_data_oe <= 1'b0;
      loss_indicator_oe <= 1'b0;
    end else if (clk_en) begin
      rx_line_clock <= rx_ck;
      rx_line_clock_oe <= ~s_tri;
      rx_data_oe <= ~s_tri;
      loss_indicator_oe <= ~s_tri;
      rx_error_in_q <= s_err;
      if (rx_upd) begin
        rx_positive_data <= s_rx_positive_data;
        rx_negative_data <= nrz_mode_bit ? s_err : s_rx_negative_data;
      end
    end
  end

  // ----------------------------------------
  // Transmit clock source and sampling
  // ----------------------------------------
  reg tx_rise;
  reg tx_fall;
  always @* begin
    case (tx_src)
      `TXSRC_MASTER: begin
        tx_rise = mclk_rise;
        tx_fall = mclk_fall;
      end
      `TXSRC_RECOVERED: begin
        tx_rise = rx_rise;
        tx_fall = rx_fall;
      end
      default: begin
        tx_rise = pin_tx_line_clock_rise;
        tx_fall = pin_tx_line_clock_fall;
      end
    endcase
  end
  wire tx_take = tx_edge_sel ? tx_rise : tx_fall;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pos_sampled <= 1'b0;
      tx_neg_sampled <= 1'b0;
      tx_sample_valid <= 1'b0;
    end else if (clk_en) begin
      tx_sample_valid <= tx_take;
      if (tx_take) begin
        tx_pos_sampled <= s_tx_positive_data;
        tx_neg_sampled <= s_tx_negative_data;
      end
    end
  end

  // ----------------------------------------
  // Loss indicator and events
  // ----------------------------------------
  reg [`STALL_WIDTH-1:0] stall_cnt;
  reg carrier_prev;
  reg stall_prev;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt <= {`STALL_WIDTH{1'b0}};
      stall_flag <= 1'b0;
      carrier_prev <= 1'b1;
      stall_prev <= 1'b0;
      events <= {`EV_WIDTH{1'b0}};
      loss_indicator_out <= 1'b0;
    end else if (clk_en) begin
      if (pin_tx_line_clock_rise | pin_tx_line_clock_fall) begin
        stall_cnt <= {`STALL_WIDTH{1'b0}};
        stall_flag <= 1'b0;
      end else if (stall_cnt == `STALL_CYCLES - 1) begin
        stall_flag <= 1'b1;
      end else begin
        stall_cnt <= stall_cnt + 1'b1;
      end
      carrier_prev <= ~s_sig;
      stall_prev <= stall_flag;
      events <= {s_err, stall_flag & ~stall_prev, ~s_sig & ~carrier_prev};
      loss_indicator_out <= loss_source_select ? stall_flag : ~s_sig;
    end
  end

endmodule // liu_system_side_pins
`default_nettype wire

/* inc/liu_pins_map.vh */
// Constants for the line interface system-side pin block.
// Assumes a 10 MHz pclk and an APB master on the register side.
`ifndef LIU_PINS_MAP_VH
`define LIU_PINS_MAP_VH
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_INT_STAT 12'h008
`define REG_INT_MASK 12'h00c
`define CTRL_RX_EDGE 0
`define CTRL_TX_EDGE 1
`define CTRL_NRZ 2
`define CTRL_LOSS_SRC 3
`define CTRL_TX_SRC_LO 4
`define CTRL_TX_SRC_HI 5
`define CTRL_WIDTH 6
`define CTRL_RESET 6'h00
`define TXSRC_PIN 2'h0
`define TXSRC_MASTER 2'h1
`define TXSRC_RECOVERED 2'h2
`define EV_CARRIER 0
`define EV_TXSTALL 1
`define EV_ERROR 2
`define EV_WIDTH 3
`define STALL_NS 5000
`define PCLK_NS 100
`define STALL_CYCLES (`STALL_NS / `PCLK_NS)
`define STALL_WIDTH 6
`define CARRIER_LIMIT 8'h20
`endif

/* test/framer_model.sv */
// Framer model driving the transmit clock and data pins.
// Assumes the bench picks the sampling edge and may stop the clock.
`default_nettype none
module framer_model (
  input wire logic run,
  input wire logic tx_edge,
  output logic tx_line_clock,
  output logic tx_positive_data,
  output logic tx_negative_data,
  output logic exp_pos,
  output logic exp_neg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pat;
  initial begin
    {tx_line_clock, tx_positive_data, tx_negative_data, exp_pos, exp_neg} = 5'h00;
    pat = 8'h5a;
    forever begin
      #400;
      if (run) begin
        tx_line_clock = ~tx_line_clock;
        if (tx_line_clock != tx_edge) begin
          pat = {pat[6:0], pat[7]};
          tx_positive_data = pat[0];
          tx_negative_data = pat[3] & ~pat[0];
        end else begin
          exp_pos = tx_positive_data;
          exp_neg = tx_negative_data;
          tx_positive_data <= #200 ~exp_pos;
          tx_negative_data <= #200 ~exp_neg;
        end
      end
    end
  end
endmodule // framer_model
`default_nettype wire

/* test/liu_pins_asserts.sv */
// Pin-level assertions for the system-side pin block.
// Assumes a bind onto the liu_system_side_pins ports.
`default_nettype none
module liu_pins_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tristate_ctrl,
  input wire logic bus_flavor_select,
  input wire logic bus_iface_select_hi,
  input wire logic read_or_data_strobe_n,
  input wire logic write_or_direction,
  input wire logic strobe_flavor,
  input wire logic parallel_active,
  input wire logic host_read_strobe,
  input wire logic host_write_strobe,
  input wire logic loss_indicator_oe,
  input wire logic rx_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Checks
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_strobe(d);
    (bus_flavor_select && !bus_iface_select_hi && !read_or_data_strobe_n &&
      write_or_direction == d) [*6];
  endsequence
  a_tri_loss: assert property (tristate_ctrl [*6] |-> !loss_indicator_oe)
    else $error("loss oe in tri-state");
  a_tri_rxdata: assert property (tristate_ctrl [*6] |-> !rx_data_oe)
    else $error("rx oe in tri-state");
  a_par_on: assert property (!bus_iface_select_hi [*6] |-> parallel_active)
    else $error("parallel port off");
  a_par_off: assert property (bus_iface_select_hi [*6] |-> !parallel_active)
    else $error("parallel port on");
  a_flavor_strobe: assert property ((bus_flavor_select && !bus_iface_select_hi) [*6]
    |-> strobe_flavor)
    else $error("strobe timing missing");
  a_flavor_rw: assert property ((!bus_flavor_select && !bus_iface_select_hi) [*6]
    |-> !strobe_flavor)
    else $error("strobe timing wrongly set");
  a_strobe_rd: assert property (s_strobe(1'b1) |-> host_read_strobe && !host_write_strobe)
    else $error("strobe read decode");
  a_strobe_wr: assert property (s_strobe(1'b0) |-> host_write_strobe && !host_read_strobe)
    else $error("strobe write decode");
endmodule // liu_pins_asserts
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the system-side pin block.
// Assumes the design header, checker and framer model are compiled first.
`default_nettype none
`include "liu_pins_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  logic pclk, presetn, clk_en, psel, penable, pwrite, hw_reset_n, hw_mode, tristate_ctrl, e;
  logic bus_flavor_select, bus_iface_select_hi, read_or_data_strobe_n, write_or_direction;
  logic master_clock, line_signal_present, tx_edge, run, pready, pslverr, irq, tx_sample_valid;
  logic tx_pos_sampled, tx_neg_sampled, loss_indicator_out, loss_indicator_oe, rx_data_oe;
  logic rx_line_clock_oe, exp_pos, exp_neg;
  logic rx_line_clock, rx_positive_data, rx_negative_data, rlc_prev;
  wire tx_line_clock, tx_positive_data, tx_negative_data;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int bad_count, n_checks, cnt;
  row_t rows [3] = '{'{`REG_CTRL, 32'h0000_0015, 32'h0000_0015, 1'b0},
    '{`REG_INT_MASK, 32'h0000_0005, 32'h0000_0005, 1'b0},
    '{12'h010, 32'h0000_0001, 32'h0000_0000, 1'b1}};
  liu_system_side_pins i_liu_system_side_pins (.pclk, .presetn, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .hw_reset_n, .hw_mode,
    .tristate_ctrl, .bus_flavor_select, .bus_iface_select_hi, .read_or_data_strobe_n,
    .address_latch_strobe(1'b0), .write_or_direction, .host_read_strobe(),
    .host_write_strobe(), .host_addr_strobe(), .strobe_flavor(), .parallel_active(),
    .master_clock, .recovered_clock(tx_line_clock), .line_signal_present,
    .rx_pos_in(tx_positive_data), .rx_neg_in(tx_negative_data), .rx_error_in(1'b0),
    .rx_line_clock, .rx_line_clock_oe, .rx_positive_data, .rx_negative_data, .rx_data_oe,
    .tx_line_clock, .tx_positive_data, .tx_negative_data, .tx_pos_sampled, .tx_neg_sampled,
    .tx_sample_valid, .loss_indicator_out, .loss_indicator_oe);
  framer_model i_framer_model (.run, .tx_edge, .tx_line_clock, .tx_positive_data,
    .tx_negative_data, .exp_pos, .exp_neg);
  // -----
  // Tasks
  // -----
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    master_clock = 1'b0;
    forever #244 master_clock = ~master_clock;
  end
  initial begin
    #500000;
    bad_count++;
    end_of_test();
  end
  initial begin
    {clk_en, hw_reset_n, line_signal_present, run, read_or_data_strobe_n} = 5'h1f;
    {presetn, psel, penable, pwrite, hw_mode, tristate_ctrl, tx_edge} = 7'h00;
    {bus_flavor_select, bus_iface_select_hi, write_or_direction, paddr, pwdata} = 47'h0;
    cyc(6);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i += 4) begin
      apb(1'b0, i[11:0], 32'h0);
      chk("reset value", 32'h0, q);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("read data", rows[i].q, q);
      chk("read error", 32'(rows[i].e), 32'(e));
    end
    $display("register test done");
    apb(1'b1, `REG_INT_MASK, 32'h0000_0002);
    for (int k = 0; k < 2; k++) begin
      tx_edge <= k[0];
      apb(1'b1, `REG_CTRL, {30'h0, k[0], ~k[0]});
      cyc(16);
      cnt = 0;
      repeat (80) begin
        @(posedge pclk);
        if (tx_sample_valid === 1'b1) begin
          cnt++;
          chk("tx pos", 32'(exp_pos), 32'(tx_pos_sampled));
          chk("tx neg", 32'(exp_neg), 32'(tx_neg_sampled));
          chk("rx pos", 32'(exp_pos), 32'(rx_positive_data));
          chk("rx neg", 32'(exp_neg), 32'(rx_negative_data));
        end
      end
      chk("tx samples", 32'h0000_000a, cnt[31:0]);
    end
    $display("transmit edge test done");
    apb(1'b1, `REG_CTRL, 32'h0000_0008);
    run <= 1'b0;
    cyc(25);
    chk("loss early", 32'h0, 32'(loss_indicator_out));
    cyc(45);
    chk("loss stall", 32'h1, 32'(loss_indicator_out));
    chk("irq stall", 32'h1, 32'(irq));
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("status stall", 32'h2, q);
    apb(1'b1, `REG_INT_MASK, 32'h0);
    cyc(3);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, `REG_INT_STAT, 32'h0000_0002);
    apb(1'b1, `REG_INT_MASK, 32'h0000_0002);
    cyc(3);
    chk("irq cleared", 32'h0, 32'(irq));
    run <= 1'b1;
    cyc(20);
    chk("loss back", 32'h0, 32'(loss_indicator_out));
    apb(1'b1, `REG_CTRL, 32'h0);
    line_signal_present <= 1'b0;
    cnt = 0;
    rlc_prev = rx_line_clock;
    repeat (100) begin
      @(posedge pclk);
      if (rx_line_clock !== rlc_prev) begin
        cnt++;
      end
      rlc_prev = rx_line_clock;
    end
    chk("rx clock fallback", 32'h1, 32'(cnt >= 35));
    chk("carrier loss", 32'h1, 32'(loss_indicator_out));
    line_signal_present <= 1'b1;
    hw_mode <= 1'b1;
    cyc(100);
    chk("carrier back", 32'h0, 32'(loss_indicator_out));
    apb(1'b1, `REG_CTRL, 32'h0000_0008);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("hw mode ctrl", 32'h0, q);
    hw_mode <= 1'b0;
    apb(1'b1, `REG_CTRL, 32'h0000_002f);
    hw_reset_n <= 1'b0;
    cyc(2);
    hw_reset_n <= 1'b1;
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("hw reset ctrl", 32'h0, q);
    tristate_ctrl <= 1'b1;
    {bus_flavor_select, read_or_data_strobe_n, write_or_direction} <= 3'b101;
    cyc(8);
    chk("oe off", 32'h0, {29'h0, loss_indicator_oe, rx_data_oe, rx_line_clock_oe});
    tristate_ctrl <= 1'b0;
    write_or_direction <= 1'b0;
    cyc(8);
    chk("oe on", 32'h7, {29'h0, loss_indicator_oe, rx_data_oe, rx_line_clock_oe});
    {bus_flavor_select, bus_iface_select_hi, read_or_data_strobe_n} <= 3'b011;
    cyc(8);
    $display("pin test done");
    end_of_test();
  end
endmodule // tb_top
bind liu_system_side_pins liu_pins_asserts i_liu_pins_asserts (.pclk, .presetn, .tristate_ctrl,
  .bus_flavor_select, .bus_iface_select_hi, .read_or_data_strobe_n, .write_or_direction,
  .strobe_flavor, .parallel_active, .host_read_strobe, .host_write_strobe, .loss_indicator_oe,
  .rx_data_oe);
`default_nettype wire
